// [include/wwdt_if.sv]
// Carrier between watchdog control, counter and access checker
`timescale 1ns/1ps
interface wwdt_if;
  import wwdt_pkg::*;
  logic                   ls_tick;
  logic                   run;
  logic                   clear;
  logic [2:0]             ovf_sel;
  logic [1:0]             win_sel;
  logic [CNT_W-1:0]       count;
  logic                   ovf_hit;
  logic                   win_open;
  logic                   det_en;
  logic [MEM_W-1:0]       rom_top;
  logic [MEM_W-1:0]       ram_base;
  logic                   fetch_valid;
  logic [MEM_W-1:0]       fetch_addr;
  logic                   data_valid;
  logic [MEM_W-1:0]       data_addr;
  logic                   illegal;

  modport ctl (output ls_tick, run, clear, ovf_sel, win_sel, det_en, rom_top, ram_base,
               fetch_valid, fetch_addr, data_valid, data_addr,
               input count, ovf_hit, win_open, illegal);
  modport cnt (input ls_tick, run, clear, ovf_sel, win_sel,
               output count, ovf_hit, win_open);
  modport acc (input det_en, rom_top, ram_base, fetch_valid, fetch_addr,
               data_valid, data_addr, output illegal);
endinterface : wwdt_if

// [include/wwdt_pkg.sv]
// Constants, register map and helper functions of the windowed watchdog
package wwdt_pkg;

  localparam int          ADDR_W        = 18;
  localparam int          DATA_W        = 32;
  localparam int          CNT_W         = 17;
  localparam int          MEM_W         = 16;

  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_REFRESH   = 16'hFF9B;
  localparam logic [15:0] IDX_STATUS    = 16'hFFA0;
  localparam logic [15:0] IDX_COUNT     = 16'hFFA1;
  localparam logic [15:0] IDX_CONFIG    = 16'hFFA2;

  localparam logic [7:0]  REFRESH_KEY   = 8'hAC;
  localparam logic [7:0]  RST_VAL_ON    = 8'h9A;
  localparam logic [7:0]  RST_VAL_OFF   = 8'h1A;

  // Option byte fields
  localparam int          OPT_LOCK_BIT  = 0;
  localparam int          OPT_OVF_LSB   = 1;
  localparam int          OPT_EN_BIT    = 4;
  localparam int          OPT_WIN_LSB   = 5;
  localparam logic [7:0]  OPT_RST_VAL   = 8'h00;

  // Status register fields
  localparam int          ST_REQ_BIT    = 0;
  localparam int          ST_PEND_BIT   = 1;
  localparam int          ST_FIRST_BIT  = 2;
  localparam int          ST_CAUSE_BIT  = 4;

  localparam int          OVF_BASE_EXP  = 10;
  localparam logic [15:0] DATA_FREE_LO  = 16'hFB00;

  // Last count value before overflow, 2^(10+n) cycles
  function automatic logic [CNT_W-1:0] wwdt_ovf_last(input logic [2:0] sel);
    logic [CNT_W:0] full;
    full = 18'(1) << (OVF_BASE_EXP + int'(sel));
    return CNT_W'(full - 18'(1));
  endfunction : wwdt_ovf_last

  // First count of the open window; open part is the final 25/50/75/100 %
  function automatic logic [CNT_W-1:0] wwdt_win_start(input logic [2:0] sel,
                                                      input logic [1:0] win);
    logic [CNT_W:0] full;
    full = 18'(1) << (OVF_BASE_EXP + int'(sel));
    unique case (win)
      2'h0:    return CNT_W'((full >> 2) * 18'(3));
      2'h1:    return CNT_W'(full >> 1);
      2'h2:    return CNT_W'(full >> 2);
      default: return '0;
    endcase
  endfunction : wwdt_win_start

endpackage : wwdt_pkg

// [logic/wwdt_access_check.sv]
// Illegal fetch and data access detector
`timescale 1ns/1ps
module wwdt_access_check (
  input  wire logic i_mclk,   // System clock
  input  wire logic i_reset,  // Async reset, active high
  wwdt_if.acc       ab        // Address monitor signals
);
  import wwdt_pkg::*;

  logic illegal_r;

  function automatic logic in_region(input logic [MEM_W-1:0] a,
                                     input logic [MEM_W-1:0] top,
                                     input logic [MEM_W-1:0] base);
    return (a < top) || (a >= base);
  endfunction : in_region

  assign ab.illegal = illegal_r;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= ab.det_en &&
                   ((ab.fetch_valid && !in_region(ab.fetch_addr, ab.rom_top, ab.ram_base)) ||
                    (ab.data_valid && !in_region(ab.data_addr, ab.rom_top, ab.ram_base) &&
                     (ab.data_addr < DATA_FREE_LO)));
    end
  end

endmodule : wwdt_access_check

// [logic/wwdt_counter.sv]
// Watchdog up-counter on low-speed ticks with overflow and window decode
`timescale 1ns/1ps
module wwdt_counter (
  input  wire logic i_mclk,   // System clock
  input  wire logic i_reset,  // Async reset, active high
  wwdt_if.cnt       cb        // Counter control and state
);
  import wwdt_pkg::*;

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] last;

  assign last        = wwdt_ovf_last(cb.ovf_sel);
  assign cb.count    = count_r;
  // Clear beats a coincident overflow so a late refresh still counts
  assign cb.ovf_hit  = cb.run && cb.ls_tick && !cb.clear && (count_r == last);
  assign cb.win_open = (count_r >= wwdt_win_start(cb.ovf_sel, cb.win_sel));

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      count_r <= '0;
    end else if (cb.clear) begin
      // Restart at once; only the tick phase adds error
      count_r <= '0;
    end else if (cb.run && cb.ls_tick) begin
      // Held value is kept while run is low, resumes from there
      count_r <= (count_r == last) ? '0 : count_r + CNT_W'(1);
    end
  end

endmodule : wwdt_counter

// [logic/wwdt_top.sv]
// Windowed watchdog timer with APB register access
// Operation
// - Count only on low-speed oscillator clock edges
// - Bit-manipulation access to refresh register resets
// - Refresh write other than ACH resets
// - Key write clears counter, restarts from zero
// - Later writes in closed window reset
// - First key write clears regardless of window
// - Fetch outside configured memory resets
// - Data access outside memory resets, FB00H-FFFFH allowed
// - Watchdog reset sets cause flag bit 4
// - Configuration comes from option byte fields
// - Refresh reset value 9AH enabled, 1AH disabled
// - Refresh reads return reset value, never key
// - Enable bit gates counter and access detection
// - Refresh fault with stopped clock pends until resume
// - Refresh timing error at most two periods
// - Refresh accepted just before overflow
// - Lock clear halts count in HALT, STOP
// - Counting resumes from held value
// - Software oscillator stop freezes count when unlocked
// - Counting continues during flash self-programming
// - Overflow time is 2^(10+n) cycles
// - Window open final 25/50/75/100 percent
`timescale 1ns/1ps
module wwdt_top (
  input  wire logic                          i_mclk,        // System clock, 50 MHz
  input  wire logic                          i_reset,       // Async reset, active high
  input  wire logic                          i_psel,        // APB select
  input  wire logic                          i_penable,     // APB enable
  input  wire logic                          i_pwrite,      // APB direction
  input  wire logic [wwdt_pkg::ADDR_W-1:0]   i_paddr,       // APB byte address
  input  wire logic [wwdt_pkg::DATA_W-1:0]   i_pwdata,      // APB write data
  input  wire logic [3:0]                    i_pstrb,       // APB write strobes
  output logic                               o_pready,      // APB ready
  output logic [wwdt_pkg::DATA_W-1:0]        o_prdata,      // APB read data
  output logic                               o_pslverr,     // APB error
  input  wire logic                          i_bit_access,  // CPU bit-manipulation access flag
  input  wire logic                          i_lsclk,       // Low-speed oscillator clock level
  input  wire logic [7:0]                    i_option_byte, // Option byte value
  input  wire logic                          i_halt,        // CPU in HALT mode
  input  wire logic                          i_stop,        // CPU in STOP mode
  input  wire logic                          i_lsosc_stop,  // Low-speed oscillator stop bit
  input  wire logic [wwdt_pkg::MEM_W-1:0]    i_rom_top,     // End of internal code memory
  input  wire logic [wwdt_pkg::MEM_W-1:0]    i_ram_base,    // Start of internal RAM
  input  wire logic                          i_fetch_valid, // Instruction fetch strobe
  input  wire logic [wwdt_pkg::MEM_W-1:0]    i_fetch_addr,  // Instruction fetch address
  input  wire logic                          i_data_valid,  // Data access strobe
  input  wire logic [wwdt_pkg::MEM_W-1:0]    i_data_addr,   // Data access address
  output logic                               o_reset_req,   // Internal reset request
  output logic                               o_reset_cause  // Watchdog reset cause flag
);
  import wwdt_pkg::*;

  wwdt_if wif ();

  // Option byte, caught after reset release
  logic             opt_loaded_r;
  logic [7:0]       opt_r;
  logic             opt_en;
  logic             opt_lock;
  logic [2:0]       opt_ovf;
  logic [1:0]       opt_win;

  // Low-speed clock edge detect
  logic             lsclk_d_r;
  logic             ls_tick;
  logic             src_run;
  logic             cnt_run;

  // APB decode
  logic             setup;
  logic             access;
  logic             wr_done;
  logic [15:0]      idx;
  logic             addr_ok;
  logic             sel_refresh;
  logic             sel_status;
  logic             sel_count;
  logic             sel_config;
  logic             mapped;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] prdata_r;
  logic             pslverr_r;

  // Refresh evaluation
  logic [7:0]       refresh_rst_val;
  logic             refresh_acc;
  logic             refresh_wr;
  logic             key_ok;
  logic             first_done_r;
  logic             refresh_fault;
  logic             refresh_clear;
  logic             fault_now;

  // Reset request
  logic             pend_r;
  logic             req_r;
  logic             cause_r;
  logic             wdt_event;
  logic             cause_clr;

  assign opt_en   = opt_r[OPT_EN_BIT];
  assign opt_lock = opt_r[OPT_LOCK_BIT];
  assign opt_ovf  = opt_r[OPT_OVF_LSB +: 3];
  assign opt_win  = opt_r[OPT_WIN_LSB +: 2];

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      opt_loaded_r <= 1'b0;
      opt_r        <= OPT_RST_VAL;
    end else if (!opt_loaded_r) begin
      opt_loaded_r <= 1'b1;
      opt_r        <= i_option_byte;
    end
  end

  // Low-speed clock is slow and synchronous here, so an edge detect suffices
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      lsclk_d_r <= 1'b0;
    end else begin
      lsclk_d_r <= i_lsclk;
    end
  end

  assign ls_tick = i_lsclk && !lsclk_d_r;

  // Locked oscillator cannot be stopped by software
  assign src_run = !(i_lsosc_stop && !opt_lock);
  // Flash self-programming is not a stop condition
  assign cnt_run = opt_loaded_r && opt_en && src_run &&
                   !((i_halt || i_stop) && !opt_lock);

  // APB slave, zero wait states, read data latched in setup
  assign setup   = i_psel && !i_penable;
  assign access  = i_psel && i_penable;
  assign idx     = i_paddr[ADDR_W-1:2];
  assign addr_ok = (i_paddr[1:0] == 2'h0);

  assign sel_refresh = addr_ok && (idx == IDX_REFRESH);
  assign sel_status  = addr_ok && (idx == IDX_STATUS);
  assign sel_count   = addr_ok && (idx == IDX_COUNT);
  assign sel_config  = addr_ok && (idx == IDX_CONFIG);
  assign mapped      = sel_refresh || sel_status || sel_count || sel_config;

  assign o_pready  = 1'b1;
  assign o_prdata  = prdata_r;
  assign o_pslverr = pslverr_r && access;
  assign wr_done   = access && i_pwrite && mapped;

  assign refresh_rst_val = opt_en ? RST_VAL_ON : RST_VAL_OFF;

  always_comb begin
    rdata_nxt = '0;
    if (sel_refresh) begin
      rdata_nxt[7:0] = refresh_rst_val;
    end else if (sel_status) begin
      rdata_nxt[ST_REQ_BIT]   = req_r;
      rdata_nxt[ST_PEND_BIT]  = pend_r;
      rdata_nxt[ST_FIRST_BIT] = first_done_r;
      rdata_nxt[ST_CAUSE_BIT] = cause_r;
    end else if (sel_count) begin
      rdata_nxt[CNT_W-1:0] = wif.count;
    end else if (sel_config) begin
      rdata_nxt[7:0] = opt_r;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= i_pwrite ? '0 : rdata_nxt;
      pslverr_r <= !mapped;
    end
  end

  // Any refresh access, read or write, is judged once per transfer
  assign refresh_acc = access && sel_refresh;
  assign refresh_wr  = refresh_acc && i_pwrite && i_pstrb[0];
  assign key_ok      = (i_pwdata[7:0] == REFRESH_KEY);

  always_comb begin
    refresh_fault = 1'b0;
    refresh_clear = 1'b0;
    if (opt_loaded_r && opt_en && refresh_acc) begin
      if (i_bit_access) begin
        refresh_fault = 1'b1;
      end else if (refresh_wr) begin
        if (!key_ok) begin
          refresh_fault = 1'b1;
        end else if (!first_done_r) begin
          refresh_clear = 1'b1;
        end else if (wif.win_open) begin
          refresh_clear = 1'b1;
        end else begin
          refresh_fault = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      first_done_r <= 1'b0;
    end else if (refresh_clear) begin
      first_done_r <= 1'b1;
    end
  end

  // Counter and access checker
  assign wif.ls_tick     = ls_tick;
  assign wif.run         = cnt_run;
  assign wif.clear       = refresh_clear;
  assign wif.ovf_sel     = opt_ovf;
  assign wif.win_sel     = opt_win;
  assign wif.det_en      = opt_loaded_r && opt_en;
  assign wif.rom_top     = i_rom_top;
  assign wif.ram_base    = i_ram_base;
  assign wif.fetch_valid = i_fetch_valid;
  assign wif.fetch_addr  = i_fetch_addr;
  assign wif.data_valid  = i_data_valid;
  assign wif.data_addr   = i_data_addr;

  wwdt_counter u_counter (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .cb      (wif.cnt)
  );

  wwdt_access_check u_access (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .ab      (wif.acc)
  );

  // Refresh faults with the source clock stopped wait for its next edge
  assign fault_now = refresh_fault && src_run;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      pend_r <= 1'b0;
    end else if (refresh_fault && !src_run) begin
      pend_r <= 1'b1;
    end else if (pend_r && ls_tick) begin
      pend_r <= 1'b0;
    end
  end

  assign wdt_event = fault_now || (pend_r && ls_tick) ||
                     wif.ovf_hit || wif.illegal;

  // Request holds until system reset; the system acts on it
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      req_r <= 1'b0;
    end else if (wdt_event) begin
      req_r <= 1'b1;
    end
  end

  assign o_reset_req = req_r;

  // Cause flag: write one to clear, a new event wins over the clear
  assign cause_clr = wr_done && sel_status && i_pstrb[0] && i_pwdata[ST_CAUSE_BIT];

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cause_r <= 1'b0;
    end else if (wdt_event) begin
      cause_r <= 1'b1;
    end else if (cause_clr) begin
      cause_r <= 1'b0;
    end
  end

  assign o_reset_cause = cause_r;

endmodule : wwdt_top

// [verif/wwdt_cpu_model.sv]
// CPU-side bus master model for the watchdog register port
`timescale 1ns/1ps
module wwdt_cpu_model (
  input  wire logic                        i_mclk,      // Clock
  input  wire logic                        i_pready,    // Slave ready
  input  wire logic [wwdt_pkg::DATA_W-1:0] i_prdata,    // Read data
  input  wire logic                        i_pslverr,   // Slave error
  output logic                             o_psel,      // Select
  output logic                             o_penable,   // Access phase
  output logic                             o_pwrite,    // Direction
  output logic [wwdt_pkg::ADDR_W-1:0]      o_paddr,     // Byte address
  output logic [wwdt_pkg::DATA_W-1:0]      o_pwdata,    // Write data
  output logic [3:0]                       o_pstrb,     // Byte strobes
  output logic                             o_bit_access // Bit-manipulation marker
);
  import wwdt_pkg::*;
  initial begin
    {o_psel, o_penable, o_pwrite, o_bit_access} = 4'h0;
    o_pstrb = 4'hF;
    o_paddr = '0;
    o_pwdata = '0;
  end
  // Caller times key writes into the open window
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic b, output logic [DATA_W-1:0] r, output logic e);
    @(posedge i_mclk);
    {o_psel, o_penable, o_pwrite, o_bit_access} <= {2'b10, w, b};
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    do @(posedge i_mclk); while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    {o_psel, o_penable, o_bit_access} <= 3'h0;
    // Stale data would hide a slave that samples too late
    o_pwdata <= ~d;
  endtask : xfer
endmodule : wwdt_cpu_model

// [verif/wwdt_top_bench.sv]
// Directed bench for the windowed watchdog
`timescale 1ns/1ps
module wwdt_top_bench;
  import wwdt_pkg::*;
  localparam logic [17:0] A_REF = {IDX_REFRESH, 2'b00};
  localparam logic [17:0] A_ST  = {IDX_STATUS, 2'b00};
  localparam logic [17:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [17:0] A_CFG = {IDX_CONFIG, 2'b00};
  logic        i_mclk, i_reset, halt, stp, osc_stop, ls_run, fv, dv, err;
  logic        psel, pen, pwr, bacc, pready, pslverr, req, cause;
  logic [1:0]  ls_div;
  logic [3:0]  pstrb;
  logic [7:0]  opt;
  logic [15:0] fa, da;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int          fails, tests_run;
  wwdt_top dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_bit_access(bacc), .i_lsclk(ls_div[1]), .i_option_byte(opt),
    .i_halt(halt), .i_stop(stp), .i_lsosc_stop(osc_stop), .i_rom_top(16'h8000),
    .i_ram_base(16'hFC00), .i_fetch_valid(fv), .i_fetch_addr(fa), .i_data_valid(dv),
    .i_data_addr(da), .o_reset_req(req), .o_reset_cause(cause));
  wwdt_cpu_model cpu (
    .i_mclk(i_mclk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
    .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb),
    .o_bit_access(bacc));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Low-speed oscillator stand-in: one tick every 4 cycles
  always @(posedge i_mclk) if (ls_run) ls_div <= ls_div + 2'h1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc
  task automatic rst(input logic [7:0] o);
    i_reset <= 1'b1;
    opt <= o;
    {halt, stp, osc_stop, ls_run} <= 4'h1;
    cyc(4);
    i_reset <= 1'b0;
    cyc(3);
  endtask : rst
  task automatic wr(input logic [31:0] d, input logic b);
    cpu.xfer(1'b1, A_REF, d, b, rd, err);
  endtask : wr
  task automatic rdr(input logic [17:0] a);
    cpu.xfer(1'b0, a, 32'h0, 1'b0, rd, err);
  endtask : rdr
  task automatic acc(input logic f, input logic [15:0] a);
    @(posedge i_mclk);
    {fv, dv, fa, da} <= {f, !f, a, a};
    @(posedge i_mclk);
    {fv, dv} <= 2'h0;
    cyc(4);
  endtask : acc
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    {i_reset, ls_run, halt, stp, osc_stop, fv, dv} = 7'h60;
    {ls_div, fa, da, opt} = '0;
    fails = 0;
    tests_run = 0;
    rst(8'h70);
    rdr(A_REF);
    chk(rd, 32'h9A, "refresh read enabled");
    rdr(A_CFG);
    chk(rd, 32'h70, "captured option");
    cyc(400);
    wr(32'hAC, 1'b0);
    rdr(A_CNT);
    chk(32'(rd < 32'h3), 32'h1, "count cleared by key");
    rdr(A_REF);
    chk(rd, 32'h9A, "read after key");
    rdr(18'h3FE70);
    chk(err, 32'h1, "unmapped address error");
    $display("test registers finished");
    rst(8'h70);
    cyc(4070);
    chk(req, 32'h0, "early overflow");
    cyc(40);
    chk(req, 32'h1, "overflow request");
    rdr(A_ST);
    chk(rd & 32'h11, 32'h11, "status cause");
    chk(cause, 32'h1, "cause flag");
    cpu.xfer(1'b1, A_ST, 32'h10, 1'b0, rd, err);
    rdr(A_ST);
    chk(rd & 32'h11, 32'h01, "cause cleared, request kept");
    $display("test overflow finished");
    for (int k = 0; k < 2; k++) begin
      rst(8'h70);
      wr(k ? 32'hAC : 32'h55, k[0]);
      cyc(2);
      chk(req, 32'h1, "faulty refresh");
    end
    rst(8'h60);
    rdr(A_REF);
    chk(rd, 32'h1A, "refresh read disabled");
    wr(32'h55, 1'b0);
    acc(1'b1, 16'h9000);
    rdr(A_CNT);
    chk(rd, 32'h0, "count stopped");
    chk(req, 32'h0, "detection off");
    $display("test faults and disable finished");
    rst(8'h12);
    wr(32'hAC, 1'b0);
    cyc(6400);
    wr(32'hAC, 1'b0);
    cyc(4000);
    chk(req, 32'h0, "open window key");
    wr(32'hAC, 1'b0);
    cyc(2);
    chk(req, 32'h1, "closed window key");
    rst(8'h70);
    cyc(4060);
    wr(32'hAC, 1'b0);
    cyc(4000);
    chk(req, 32'h0, "key just before overflow");
    // Half and three-quarter windows: open, then closed after the refresh
    for (int k = 0; k < 2; k++) begin
      rst(k ? 8'h50 : 8'h30);
      wr(32'hAC, 1'b0);
      cyc(k ? 1100 : 2200);
      wr(32'hAC, 1'b0);
      cyc(k ? 900 : 1900);
      chk(req, 32'h0, "wider window open key");
      wr(32'hAC, 1'b0);
      cyc(2);
      chk(req, 32'h1, "wider window closed key");
    end
    $display("test window finished");
    rst(8'h70);
    for (int k = 0; k < 2; k++) begin
      {stp, halt} <= 2'(k + 1);
      cyc(8);
      rdr(A_CNT);
      v = rd;
      cyc(200);
      rdr(A_CNT);
      chk(rd, v, "count held in low power");
      {stp, halt} <= 2'h0;
      cyc(200);
      rdr(A_CNT);
      chk(32'(rd > v && rd < v + 32'h46), 32'h1, "count resumes");
    end
    rst(8'h71);
    halt <= 1'b1;
    rdr(A_CNT);
    v = rd;
    cyc(200);
    rdr(A_CNT);
    chk(32'(rd > v), 32'h1, "count runs with lock");
    $display("test low power finished");
    rst(8'h70);
    osc_stop <= 1'b1;
    cyc(4);
    ls_run <= 1'b0;
    rdr(A_CNT);
    v = rd;
    wr(32'h55, 1'b0);
    cyc(100);
    chk(req, 32'h0, "fault held while stopped");
    rdr(A_ST);
    chk(rd & 32'h3, 32'h2, "fault pending");
    rdr(A_CNT);
    chk(rd, v, "count frozen");
    {osc_stop, ls_run} <= 2'h1;
    cyc(12);
    chk(req, 32'h1, "fault after resume");
    $display("test oscillator stop finished");
    rst(8'h70);
    acc(1'b0, 16'hFB00);
    acc(1'b0, 16'h7FFF);
    acc(1'b1, 16'hFC00);
    chk(req, 32'h0, "legal accesses");
    acc(1'b1, 16'hFB00);
    chk(req, 32'h1, "illegal fetch");
    rst(8'h70);
    acc(1'b0, 16'h9000);
    chk(req, 32'h1, "illegal data access");
    $display("test access monitor finished");
    wrap_up();
  end
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule : wwdt_top_bench

// [verif/wwdt_top_props.sv]
// Port-level assertions for the windowed watchdog top
`timescale 1ns/1ps
module wwdt_top_chk (
  input wire logic                        i_mclk,        // Clock
  input wire logic                        i_reset,       // Async reset
  input wire logic                        i_psel,        // APB select
  input wire logic                        i_penable,     // APB enable
  input wire logic                        i_pwrite,      // APB direction
  input wire logic [wwdt_pkg::ADDR_W-1:0] i_paddr,       // APB address
  input wire logic [wwdt_pkg::DATA_W-1:0] i_pwdata,      // APB write data
  input wire logic [3:0]                  i_pstrb,       // APB strobes
  input wire logic [wwdt_pkg::DATA_W-1:0] o_prdata,      // APB read data
  input wire logic                        i_bit_access,  // Bit access flag
  input wire logic                        i_lsosc_stop,  // Oscillator stop
  input wire logic [7:0]                  i_option_byte, // Option byte
  input wire logic [wwdt_pkg::MEM_W-1:0]  i_rom_top,     // Code end
  input wire logic [wwdt_pkg::MEM_W-1:0]  i_ram_base,    // RAM start
  input wire logic                        i_fetch_valid, // Fetch strobe
  input wire logic [wwdt_pkg::MEM_W-1:0]  i_fetch_addr,  // Fetch address
  input wire logic                        i_data_valid,  // Data strobe
  input wire logic [wwdt_pkg::MEM_W-1:0]  i_data_addr,   // Data address
  input wire logic                        o_reset_req,   // Reset request
  input wire logic                        o_reset_cause  // Cause flag
);
  import wwdt_pkg::*;
  logic en;
  logic run_src;
  logic ref_acc;
  // Option byte is held stable by the bench, so the live value stands for the captured one
  assign en      = i_option_byte[OPT_EN_BIT];
  assign run_src = !(i_lsosc_stop && !i_option_byte[OPT_LOCK_BIT]);
  assign ref_acc = i_psel && i_penable && (i_paddr == {IDX_REFRESH, 2'b00});
  default clocking dcb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  chk_req_sticky: assert property (o_reset_req |=> o_reset_req)
    else $error("reset request dropped");
  chk_cause_set: assert property ($rose(o_reset_req) |-> ##[0:1] o_reset_cause)
    else $error("cause flag not set");
  chk_bad_key: assert property (ref_acc && i_pwrite && i_pstrb[0] && i_pwdata[7:0] != REFRESH_KEY
    && en && run_src |=> o_reset_req) else $error("wrong key not faulted");
  chk_bit_fault: assert property (ref_acc && i_bit_access && en && run_src |=> o_reset_req)
    else $error("bit access not faulted");
  chk_ref_read: assert property (ref_acc && !i_pwrite
    |-> o_prdata == {24'h000000, (en ? RST_VAL_ON : RST_VAL_OFF)}) else $error("refresh read value");
  chk_fetch_bad: assert property (i_fetch_valid && en && i_fetch_addr >= i_rom_top
    && i_fetch_addr < i_ram_base |-> ##[1:2] o_reset_req) else $error("illegal fetch missed");
  chk_data_bad: assert property (i_data_valid && en && i_data_addr >= i_rom_top
    && i_data_addr < i_ram_base && i_data_addr < DATA_FREE_LO |-> ##[1:2] o_reset_req)
    else $error("illegal data access missed");
  chk_off_quiet: assert property (!en |-> !o_reset_req)
    else $error("request while disabled");
  chk_pend_wait: assert property (!run_src && !i_fetch_valid && !i_data_valid && !$past(i_fetch_valid)
    && !$past(i_data_valid) |=> !$rose(o_reset_req)) else $error("request while source stopped");
endmodule : wwdt_top_chk
bind wwdt_top wwdt_top_chk u_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
  .i_bit_access(i_bit_access), .i_lsosc_stop(i_lsosc_stop), .i_option_byte(i_option_byte),
  .i_rom_top(i_rom_top), .i_ram_base(i_ram_base), .i_fetch_valid(i_fetch_valid),
  .i_fetch_addr(i_fetch_addr), .i_data_valid(i_data_valid), .i_data_addr(i_data_addr),
  .o_reset_req(o_reset_req), .o_reset_cause(o_reset_cause)
);
